// file: core/auto_xfer_defines.vh
// Constants of the automatic serial buffer transfer engine.
// Assumes a 6-bit register address with the buffer RAM in the upper half.
`ifndef AUTO_XFER_DEFINES_VH
`define AUTO_XFER_DEFINES_VH

// Register addresses
`define ADDR_W 6
`define REG_MODE 6'h00
`define REG_CTRL 6'h01
`define REG_GAP 6'h02
`define REG_PTR 6'h03
`define REG_SHIFT 6'h04
`define REG_STAT 6'h05
`define RAM_SEL_BIT 5

// Buffer RAM shape: 32 bytes, lowest byte sent last
`define RAM_AW 5
`define DATA_W 8

// serial_mode_reg fields
`define MODE_ENABLE_BIT 7
`define MODE_AUTO_BIT 5

// auto_xfer_control fields
`define CTRL_RX_ON_BIT 7
`define CTRL_REPEAT_BIT 6
`define CTRL_ACTIVE_BIT 3

// byte_gap_setting fields; bits 6 and 5 always read zero
`define GAP_TOP_BIT 7
`define GAP_N_MSB 4

// Status register field
`define STAT_IRQ_BIT 0

// Reset values
`define MODE_RESET 8'h00
`define CTRL_RESET 8'h00
`define GAP_RESET 8'h00
`define PTR_RESET 5'h00

// Gap timing in system clocks: (n+1)*64 plus a fixed overhead
`define GAP_SHIFT 6
`define GAP_EXTRA 12'h01C
`define GAP_CNT_W 12

// Bits per serial unit
`define BITS_PER_UNIT 4'h8

`endif

// file: core/buffer_ram.v
// Buffer RAM of the transfer engine: 32 bytes, one write port, two
// registered read ports (software and engine).
// Assumes the owner arbitrates the single write port.
`timescale 1ns/1ps
`include "auto_xfer_defines.vh"

module buffer_ram (
    input wire clk,
    input wire wrEn,
    input wire [`RAM_AW-1:0] wrAddr,
    input wire [`DATA_W-1:0] wrData,
    input wire [`RAM_AW-1:0] rdAddrA,
    output reg [`DATA_W-1:0] rdDataA,
    input wire [`RAM_AW-1:0] rdAddrB,
    output reg [`DATA_W-1:0] rdDataB
);

    reg [`DATA_W-1:0] mem [0:(1<<`RAM_AW)-1];

    // Write and both reads; read data come out of a register
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end

endmodule

// file: core/auto_serial_buffer_transfer.v
// Automatic block transfer engine of a 3-wire serial interface with
// its register port and buffer RAM.
// Assumes the serial clock comes from the far side on a pin and that
// software keeps the setup order described below.
//
// Notes on behaviour
// [R1] Software fills the buffer upward from the lowest byte, first byte highest.
// [R2] Software loads the index pointer with byte count minus one.
// [R3] Software enables serial and automatic mode, sets receive, gap, then triggers.
// [R4] A shift register write only starts the block; its value is dropped.
// [R5] The byte at the pointer is copied to the shift register, then sent.
// [R6] With receive on, each received byte goes to the pointed buffer byte.
// [R7] Pointer decrements after each byte; block ends after pointer zero byte.
// [R8] The transfer-active flag clears when the block ends.
// [R9] Interrupt flag set after final byte; active flag at bit 3 shows end.
// [R10] Trigger is honoured only while the serial enable bit 7 is set.
// [R11] Transmit/receive mode shifts out and in eight bits per unit together.
// [R12] Serial input is released in transmit-only mode; no strobe or busy.
// [R13] A gap follows every byte but the last while the buffer is accessed.
// [R14] Serial data output is low whenever the active flag is clear.
// [R15] Repeat select 0 and receive on selects transmit/receive mode.
// [R16] Repeat select 0 and receive off transmits only, storing nothing.
// [R17] Transmit/receive byte end: store, decrement, load next byte.
// [R18] Transmit-only byte end: decrement then load next, no buffer write.
// [R19] Last byte: store final received byte, then set interrupt flag.
// [R20] Software leaves the gap setting alone during a block.
// [R21] Gap lies between (n+1)*64+28 clocks and (n+1)*64+36 clocks plus sck.
// [R22] Active flag stays set from trigger until the block ends.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "auto_xfer_defines.vh"

module auto_serial_buffer_transfer (
    input wire clk,
    input wire rst_b,
    input wire [`ADDR_W-1:0] regAddr,
    input wire [`DATA_W-1:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [`DATA_W-1:0] regRdData,
    input wire serialClkPin,
    input wire serialInPin,
    output reg serialOutPin,
    output reg serialInUsed,
    output reg transferActive,
    output reg serialIrq
);

    // One-hot engine states
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_FETCH = 7'h02;
    localparam [6:0] ST_LOAD = 7'h04;
    localparam [6:0] ST_ARM = 7'h08;
    localparam [6:0] ST_SHIFT = 7'h10;
    localparam [6:0] ST_STORE = 7'h20;
    localparam [6:0] ST_GAP = 7'h40;

    // Decodes a register address; used for reads and writes alike
    function isReg;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] which;
        begin
            isReg = (addr == which);
        end
    endfunction

    reg [6:0] state_q;
    reg [`DATA_W-1:0] mode_q;
    reg rxOn_q;
    reg repeatSel_q;
    reg [`DATA_W-1:0] gap_q;
    reg [`RAM_AW-1:0] ptr_q;
    reg [`DATA_W-1:0] shift_q;
    reg [3:0] bitCnt_q;
    reg [`GAP_CNT_W-1:0] gapCnt_q;
    reg irqFlag_q;
    reg ramSel_q;
    reg [`DATA_W-1:0] regFile_q;
    reg sck1_q;
    reg sck2_q;
    reg sck3_q;
    reg si1_q;
    reg si2_q;

    wire [`DATA_W-1:0] ramRdCpu;
    wire [`DATA_W-1:0] ramRdEng;
    wire sckRise;
    wire sckFall;
    wire cpuRamWrite;
    wire engRamWrite;
    wire trigger;
    wire [`GAP_CNT_W-1:0] gapLoad;
    wire [`DATA_W-1:0] ctrlRead;
    wire [`DATA_W-1:0] gapRead;

    // Two flip-flops on each pin, a third stage only for edge finding
    always @(posedge clk) begin
        // Clock stages start at the idle-high level of the link clock,
        // so that no false edge is seen right after reset
        if (!rst_b) begin
            sck1_q <= 1'b1;
            sck2_q <= 1'b1;
            sck3_q <= 1'b1;
            si1_q <= 1'b0;
            si2_q <= 1'b0;
        end else begin
            sck1_q <= serialClkPin;
            sck2_q <= sck1_q;
            sck3_q <= sck2_q;
            si1_q <= serialInPin;
            si2_q <= si1_q;
        end
    end

    assign sckRise = sck2_q & ~sck3_q;
    assign sckFall = ~sck2_q & sck3_q;

    // Start only with serial and automatic mode enabled and no block
    // running; a retrigger mid-block is ignored
    assign trigger = regWrite && isReg(regAddr, `REG_SHIFT) &&
                     mode_q[`MODE_ENABLE_BIT] && // [R10]
                     mode_q[`MODE_AUTO_BIT] && state_q == ST_IDLE; // [R4]

    assign cpuRamWrite = regWrite && regAddr[`RAM_SEL_BIT];
    // Engine write yields to a software write in the same cycle
    assign engRamWrite = state_q == ST_STORE && rxOn_q &&
                         !repeatSel_q && !cpuRamWrite; // [R6] [R15] [R16]

    // (n+1)*64 + 28 clocks of gap before the next fetch; n+1 is kept
    // six bits wide so that n = 31 gives 32 and not zero
    assign gapLoad = ({6'h00, {1'b0, gap_q[`GAP_N_MSB:0]} + 6'h01} <<
                      `GAP_SHIFT) + `GAP_EXTRA; // [R21]

    buffer_ram ram (
        .clk(clk),
        .wrEn(cpuRamWrite | engRamWrite),
        .wrAddr(cpuRamWrite ? regAddr[`RAM_AW-1:0] : ptr_q),
        .wrData(cpuRamWrite ? regWrData : shift_q),
        .rdAddrA(regAddr[`RAM_AW-1:0]),
        .rdDataA(ramRdCpu),
        .rdAddrB(ptr_q), // [R1]
        .rdDataB(ramRdEng)
    );

    // Software-written control registers
    always @(posedge clk) begin
        if (!rst_b) begin
            mode_q <= `MODE_RESET;
            rxOn_q <= 1'b0;
            repeatSel_q <= 1'b0;
            gap_q <= `GAP_RESET;
        end else if (regWrite) begin
            if (isReg(regAddr, `REG_MODE)) begin
                mode_q <= regWrData;
            end
            if (isReg(regAddr, `REG_CTRL)) begin
                rxOn_q <= regWrData[`CTRL_RX_ON_BIT];
                repeatSel_q <= regWrData[`CTRL_REPEAT_BIT];
            end
            if (isReg(regAddr, `REG_GAP)) begin
                gap_q <= regWrData;
            end
        end
    end

    // Engine: pointer, shifter, gap counter and flags
    always @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            ptr_q <= `PTR_RESET;
            shift_q <= 8'h00;
            bitCnt_q <= 4'h0;
            gapCnt_q <= 12'h000;
            irqFlag_q <= 1'b0;
            serialIrq <= 1'b0;
            serialOutPin <= 1'b0;
        end else begin
            serialIrq <= 1'b0;
            // Write 1 clears the flag; a set in the same cycle wins below
            if (regWrite && isReg(regAddr, `REG_STAT) &&
                regWrData[`STAT_IRQ_BIT]) begin
                irqFlag_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    serialOutPin <= 1'b0; // [R14]
                    // Pointer is software's only while idle
                    if (regWrite && isReg(regAddr, `REG_PTR)) begin
                        ptr_q <= regWrData[`RAM_AW-1:0]; // [R2]
                    end
                    if (trigger) begin
                        state_q <= ST_FETCH; // [R22]
                    end
                end
                ST_FETCH: begin
                    // RAM read issued from ptr_q, data valid next cycle
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    shift_q <= ramRdEng; // [R5]
                    bitCnt_q <= 4'h0;
                    state_q <= ST_ARM;
                end
                ST_ARM: begin
                    // Wait for the far side's falling edge to start a unit
                    if (sckFall) begin
                        serialOutPin <= shift_q[`DATA_W-1]; // [R5]
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sckRise) begin
                        shift_q <= {shift_q[`DATA_W-2:0], si2_q}; // [R11]
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q + 4'h1 == `BITS_PER_UNIT) begin
                            state_q <= ST_STORE; // [R11]
                        end
                    end else if (sckFall) begin
                        serialOutPin <= shift_q[`DATA_W-1];
                    end
                end
                ST_STORE: begin
                    // Store first; only then decrement or finish
                    if (engRamWrite || !rxOn_q || repeatSel_q) begin
                        if (ptr_q == 5'h00) begin
                            irqFlag_q <= 1'b1; // [R19] [R9]
                            serialIrq <= 1'b1; // [R19]
                            serialOutPin <= 1'b0; // [R14]
                            state_q <= ST_IDLE; // [R7] [R8]
                        end else begin
                            ptr_q <= ptr_q - 5'h01; // [R7] [R17] [R18]
                            gapCnt_q <= gapLoad; // [R13]
                            state_q <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    // Output keeps the last bit while the block runs
                    if (gapCnt_q == 12'h000) begin
                        state_q <= ST_FETCH; // [R13]
                    end else begin
                        gapCnt_q <= gapCnt_q - 12'h001; // [R21]
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Flags shown at pins: registered engine state, and the trigger for the active flag
    always @(posedge clk) begin
        if (!rst_b) begin
            transferActive <= 1'b0;
            serialInUsed <= 1'b0;
        end else begin
            transferActive <= state_q != ST_IDLE || trigger; // [R22]
            // Input pin is free again in transmit-only mode
            serialInUsed <= (state_q != ST_IDLE) && rxOn_q; // [R12]
        end
    end

    // Read views of the control registers
    assign ctrlRead = {rxOn_q, repeatSel_q, 2'b00,
                       state_q != ST_IDLE, 3'b000}; // [R9]
    assign gapRead = {gap_q[`GAP_TOP_BIT], 2'b00, gap_q[`GAP_N_MSB:0]};

    // Register read data, one cycle after the read strobe;
    // RAM reads mux the RAM's own output register in that cycle
    always @(posedge clk) begin
        if (!rst_b) begin
            ramSel_q <= 1'b0;
            regFile_q <= 8'h00;
        end else begin
            ramSel_q <= regRead && regAddr[`RAM_SEL_BIT];
            regFile_q <= 8'h00;
            if (regRead) begin
                if (isReg(regAddr, `REG_MODE)) begin
                    regFile_q <= mode_q;
                end
                if (isReg(regAddr, `REG_CTRL)) begin
                    regFile_q <= ctrlRead;
                end
                if (isReg(regAddr, `REG_GAP)) begin
                    regFile_q <= gapRead;
                end
                if (isReg(regAddr, `REG_PTR)) begin
                    regFile_q <= {3'b000, ptr_q};
                end
                if (isReg(regAddr, `REG_SHIFT)) begin
                    regFile_q <= shift_q;
                end
                if (isReg(regAddr, `REG_STAT)) begin
                    regFile_q <= {7'h00, irqFlag_q};
                end
            end
        end
    end

    // Output mux keeps the read word valid in exactly one cycle
    always @* begin
        regRdData = ramSel_q ? ramRdCpu : regFile_q;
    end

endmodule

// file: testbench/auto_xfer_sva.sv
// Port checker for the automatic serial buffer transfer engine.
// Assumes mode and control are written only while no block runs.
`timescale 1ns/1ps
`include "auto_xfer_defines.vh"
module auto_xfer_sva (
    input wire clk,
    input wire rst_b,
    input wire [`ADDR_W-1:0] regAddr,
    input wire [`DATA_W-1:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [`DATA_W-1:0] regRdData,
    input wire serialClkPin,
    input wire serialInPin,
    input wire serialOutPin,
    input wire serialInUsed,
    input wire transferActive,
    input wire serialIrq
);
    logic [7:0] modeQ;
    logic [7:0] ctrlQ;
    wire trig = regWrite && regAddr == `REG_SHIFT;
    // Shadow copies of mode and control, taken from bus writes
    always @(posedge clk) begin
        if (!rst_b) begin
            modeQ <= 8'h00;
            ctrlQ <= 8'h00;
        end else if (regWrite && regAddr == `REG_MODE) begin
            modeQ <= regWrData;
        end else if (regWrite && regAddr == `REG_CTRL) begin
            ctrlQ <= regWrData;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Block end: flag drops and the data line rests low
    sequence sEnd;
        ##[0:2] (!transferActive && !serialOutPin);
    endsequence
    a_start_on_enable: assert property (
        trig && modeQ[7] && modeQ[5] && !transferActive
        |-> ##[1:2] transferActive) else $error("block did not start");
    a_start_refused: assert property (
        trig && !modeQ[7] && !transferActive |-> ##1 !transferActive[*3])
        else $error("block started while disabled");
    a_end_clears: assert property (serialIrq |-> sEnd)
        else $error("active flag kept after last byte");
    a_irq_single: assert property (serialIrq |=> !serialIrq[*8])
        else $error("interrupt pulse too long");
    a_drop_has_irq: assert property (
        $fell(transferActive) |-> $past(serialIrq) || $past(serialIrq, 2))
        else $error("active flag dropped early");
    a_idle_out_low: assert property (!transferActive |-> !serialOutPin)
        else $error("data out high while idle");
    a_tx_only_free: assert property (
        transferActive && !ctrlQ[7] |-> !serialInUsed)
        else $error("serial input claimed in transmit-only mode");
    a_rx_claims_in: assert property (
        $rose(transferActive) && ctrlQ[7] |-> ##[0:2] serialInUsed)
        else $error("serial input not used while receiving");
    a_out_on_fall: assert property (
        $changed(serialOutPin) && !serialIrq |-> !serialClkPin)
        else $error("data out changed while clock high");
endmodule

bind auto_serial_buffer_transfer auto_xfer_sva chk (.clk, .rst_b,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .serialClkPin,
    .serialInPin, .serialOutPin, .serialInUsed, .transferActive, .serialIrq);

// file: testbench/serial_slave_model.sv
// Far-side serial device: makes the link clock, shifts bytes both ways.
// Assumes the engine gap never exceeds the idle time left between bytes.
`timescale 1ns/1ps
module serial_slave_model (
    input wire transferActive,
    input wire serialOutPin,
    output logic serialClkPin,
    output logic serialInPin
);
    logic [7:0] txQ[$];
    logic [7:0] rxQ[$];
    logic [7:0] t;
    logic [7:0] r;
    // Clock only within frames; long rest covers the engine's byte gap
    initial begin
        serialClkPin = 1'b1;
        serialInPin = 1'b0;
        forever begin
            wait (transferActive);
            #3010; // Keeps link edges off the system clock's edges
            while (transferActive) begin
                t = (txQ.size() > 0) ? txQ.pop_front() : 8'h00;
                for (int i = 7; i >= 0; i--) begin
                    serialClkPin = 1'b0;
                    serialInPin = t[i];
                    #200;
                    serialClkPin = 1'b1;
                    r = {r[6:0], serialOutPin};
                    #200;
                end
                rxQ.push_back(r);
                serialInPin = ~serialInPin; // Inverts the last bit instead of holding it
                #10000;
            end
        end
    end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the transfer engine.
// Assumes the register map of the defines header.
`timescale 1ns/1ps
`include "auto_xfer_defines.vh"
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [`ADDR_W-1:0] regAddr = 6'h00;
    logic [`DATA_W-1:0] regWrData = 8'h00;
    wire [`DATA_W-1:0] regRdData;
    wire serialClkPin, serialInPin, serialOutPin;
    wire serialInUsed, transferActive, serialIrq;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    auto_serial_buffer_transfer DUT (.clk(clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData),
        .serialClkPin(serialClkPin), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialInUsed(serialInUsed),
        .transferActive(transferActive), .serialIrq(serialIrq));
    serial_slave_model slave (.transferActive(transferActive),
        .serialOutPin(serialOutPin), .serialClkPin(serialClkPin),
        .serialInPin(serialInPin));
    task check(input string name, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so look there
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check($sformatf("reg %h", a), regRdData, e);
    endtask
    // Looks just after each edge, where the flag has settled
    task waitIdle;
        repeat (2) @(posedge clk);
        #1;
        while (transferActive) begin
            @(posedge clk);
            #1;
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard: two short blocks need far fewer cycles than this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(`REG_CTRL, 8'h00);
        rd(`REG_STAT, 8'h00);
        rd(6'h10, 8'h00);
        wr(`REG_GAP, 8'hFF);
        rd(`REG_GAP, 8'h9F);
        wr(`REG_MODE, 8'h20);
        wr(`REG_SHIFT, 8'h55);
        repeat (4) @(posedge clk);
        #1 check("idle", {7'h00, transferActive}, 8'h00);
        // Three bytes both ways, first byte at the top address
        wr(6'h20, 8'hA1);
        wr(6'h21, 8'hB2);
        wr(6'h22, 8'hC3);
        slave.txQ = '{8'h3C, 8'h2B, 8'h1A};
        wr(`REG_PTR, 8'h02);
        wr(`REG_MODE, 8'hA0);
        wr(`REG_CTRL, 8'h80);
        wr(`REG_GAP, 8'h00);
        wr(`REG_SHIFT, 8'hEE);
        @(posedge clk);
        #1 check("busy", {7'h00, transferActive}, 8'h01);
        check("rx pin", {7'h00, serialInUsed}, 8'h01);
        wr(`REG_PTR, 8'h00);
        rd(`REG_PTR, 8'h02);
        waitIdle;
        check("tx count", slave.rxQ.size(), 8'h03);
        check("tx byte", slave.rxQ[0], 8'hC3);
        check("tx byte", slave.rxQ[1], 8'hB2);
        check("tx byte", slave.rxQ[2], 8'hA1);
        rd(`REG_CTRL, 8'h80);
        rd(`REG_STAT, 8'h01);
        rd(6'h22, 8'h3C);
        rd(6'h21, 8'h2B);
        rd(6'h20, 8'h1A);
        rd(`REG_PTR, 8'h00);
        wr(`REG_STAT, 8'h01);
        rd(`REG_STAT, 8'h00);
        // Repeat select is stored and read back while idle
        wr(`REG_CTRL, 8'hC0);
        rd(`REG_CTRL, 8'hC0);
        // Transmit only: nothing received may land in the buffer
        slave.rxQ.delete();
        slave.txQ = '{8'h55, 8'h66};
        wr(`REG_CTRL, 8'h00);
        wr(`REG_PTR, 8'h01);
        wr(`REG_SHIFT, 8'h00);
        @(posedge clk);
        #1 check("rx pin", {7'h00, serialInUsed}, 8'h00);
        waitIdle;
        check("tx count", slave.rxQ.size(), 8'h02);
        check("tx byte", slave.rxQ[0], 8'h2B);
        check("tx byte", slave.rxQ[1], 8'h1A);
        rd(6'h21, 8'h2B);
        rd(6'h20, 8'h1A);
        rd(`REG_CTRL, 8'h00);
        rd(`REG_STAT, 8'h01);
        test_done();
    end
endmodule
